/* rtl/banked_data_memory_indirect.sv */
// What this block does
// - Status bit five selects bank one.
// - Banks span 128 bytes, registers then RAM.
// - Common registers decode alike in both banks.
// - Port zero accesses the pointed-to register.
// - Pointer zero reading the port returns zero.
// - Pointer-zero write through port changes nothing.
// - Indirect address is upper bit plus pointer.
`timescale 1ns/10ps
module banked_data_memory_indirect (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [6:0] file_addr,
  output logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic status_wr_en,
  input wire logic [7:0] status_wr_data,
  input wire logic pc_low_wr_en,
  input wire logic [7:0] pc_low_in,
  input wire logic timer_wr_en,
  input wire logic [7:0] timer_in,
  input wire logic result_wr_en,
  input wire logic [7:0] result_in,
  input wire logic intr_flags_wr_en,
  input wire logic [7:0] intr_flags_in,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  output logic [7:0] status_out,
  output logic [7:0] pointer_out,
  output logic [7:0] pc_high_latch_out,
  output logic [7:0] pc_low_out,
  output logic [7:0] timer_out,
  output logic [7:0] port_a_out,
  output logic [7:0] port_b_out,
  output logic [7:0] port_a_dir_out,
  output logic [7:0] port_b_dir_out,
  output logic [7:0] option_out,
  output logic [7:0] intr_ctrl_out,
  output logic [7:0] conv_ctrl_a_out,
  output logic [7:0] conv_ctrl_b_out,
  output logic [7:0] power_ctrl_out,
  output logic [8:0] eff_addr
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] status_ff;
  logic [7:0] pointer_ff;
  logic [7:0] pc_low_ff;
  logic [7:0] pc_high_ff;
  logic [7:0] timer_ff;
  logic [7:0] port_a_ff;
  logic [7:0] port_b_ff;
  logic [7:0] dir_a_ff;
  logic [7:0] dir_b_ff;
  logic [7:0] option_ff;
  logic [7:0] intr_ff;
  logic [7:0] conv_a_ff;
  logic [7:0] conv_b_ff;
  logic [7:0] result_ff;
  logic [7:0] power_ff;
  logic [7:0] gpr_mem [data_memory_pkg::gpr_words];
  logic [7:0] pin_a_meta_ff;
  logic [7:0] pin_a_sync_ff;
  logic [7:0] pin_b_meta_ff;
  logic [7:0] pin_b_sync_ff;
  logic [7:0] gpr_rd;
  logic [7:0] mirror_rd;

  // ****************************************
  // Address formation
  // ****************************************
  logic is_port;
  logic [8:0] indirect_addr;
  logic [8:0] direct_addr;
  logic [7:0] map_addr;
  logic self_point;
  logic do_write;
  logic in_gpr;
  logic [5:0] gpr_index;

  assign is_port = (file_addr == data_memory_pkg::indirect_data_port_offs);
  assign indirect_addr = {status_ff[data_memory_pkg::indirect_upper_address_pos],
                          pointer_ff};
  assign direct_addr = {1'b0, status_ff[data_memory_pkg::bank_select_pos],
                        file_addr};
  assign eff_addr = is_port ? indirect_addr : direct_addr;
  // Upper bit is not decoded on this family, so only eight bits map
  assign map_addr = eff_addr[7:0];
  // Low seven bits only: a pointer of 80h also counts as self
  assign self_point = is_port && (map_addr[6:0] == data_memory_pkg::indirect_data_port_offs);

  // ****************************************
  // Write gating
  // ****************************************
  // Blocked self write still lets the core update its flags
  assign do_write = wr_en && !self_point;

  // Upper-bank RAM addresses fold onto the lower bank copy
  assign in_gpr = (map_addr[6:0] >= data_memory_pkg::gpr_first) &&
                  (map_addr[6:0] <= data_memory_pkg::gpr_last);
  assign gpr_index = 6'(map_addr[6:0] - data_memory_pkg::gpr_first);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Pin reads lag the pins by two clocks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_meta_ff <= 8'h00;
      pin_a_sync_ff <= 8'h00;
      pin_b_meta_ff <= 8'h00;
      pin_b_sync_ff <= 8'h00;
    end else begin
      pin_a_meta_ff <= port_a_in;
      pin_a_sync_ff <= pin_a_meta_ff;
      pin_b_meta_ff <= port_b_in;
      pin_b_sync_ff <= pin_b_meta_ff;
    end
  end

  // ****************************************
  // Mirrored registers
  // ****************************************
  // Core-side updates lose to an explicit file write in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= data_memory_pkg::status_flags_rst;
      pointer_ff <= data_memory_pkg::zero_rst;
      pc_low_ff <= data_memory_pkg::zero_rst;
      pc_high_ff <= data_memory_pkg::zero_rst;
      intr_ff <= data_memory_pkg::zero_rst;
      result_ff <= data_memory_pkg::zero_rst;
    end else begin
      if (status_wr_en) begin
        status_ff <= status_wr_data;
      end
      if (pc_low_wr_en) begin
        pc_low_ff <= pc_low_in;
      end
      if (intr_flags_wr_en) begin
        intr_ff <= intr_flags_in;
      end
      if (result_wr_en) begin
        result_ff <= result_in;
      end
      if (do_write) begin
        case (map_addr[6:0])
          data_memory_pkg::status_flags_offs[6:0]: begin
            status_ff <= wr_data;
          end
          data_memory_pkg::file_select_pointer_offs[6:0]: begin
            pointer_ff <= wr_data;
          end
          data_memory_pkg::program_counter_low_offs[6:0]: begin
            pc_low_ff <= wr_data;
          end
          data_memory_pkg::program_counter_high_latch_offs[6:0]: begin
            pc_high_ff <= wr_data & data_memory_pkg::pc_high_mask;
          end
          data_memory_pkg::interrupt_control_offs[6:0]: begin
            intr_ff <= wr_data;
          end
          data_memory_pkg::converter_result_offs[6:0]: begin
            result_ff <= wr_data;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // Banked registers
  // ****************************************
  // Full eight-bit decode keeps the two banks apart
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_ff <= data_memory_pkg::zero_rst;
      port_a_ff <= data_memory_pkg::zero_rst;
      port_b_ff <= data_memory_pkg::zero_rst;
      dir_a_ff <= data_memory_pkg::port_a_pins_dir_rst;
      dir_b_ff <= data_memory_pkg::all_ones_rst;
      option_ff <= data_memory_pkg::all_ones_rst;
      conv_a_ff <= data_memory_pkg::zero_rst;
      conv_b_ff <= data_memory_pkg::zero_rst;
      power_ff <= data_memory_pkg::zero_rst;
    end else begin
      if (timer_wr_en) begin
        timer_ff <= timer_in;
      end
      if (do_write) begin
        case (map_addr)
          data_memory_pkg::timer_count_offs: begin
            timer_ff <= wr_data;
          end
          data_memory_pkg::port_a_pins_offs: begin
            port_a_ff <= wr_data & data_memory_pkg::port_a_pins_mask;
          end
          data_memory_pkg::port_b_pins_offs: begin
            port_b_ff <= wr_data;
          end
          data_memory_pkg::converter_control_a_offs: begin
            conv_a_ff <= wr_data & data_memory_pkg::converter_control_a_mask;
          end
          data_memory_pkg::option_config_offs: begin
            option_ff <= wr_data;
          end
          data_memory_pkg::port_a_direction_offs: begin
            dir_a_ff <= wr_data & data_memory_pkg::port_a_pins_mask;
          end
          data_memory_pkg::port_b_direction_offs: begin
            dir_b_ff <= wr_data;
          end
          data_memory_pkg::power_control_flags_offs: begin
            power_ff <= wr_data & data_memory_pkg::power_control_mask;
          end
          data_memory_pkg::converter_control_b_offs: begin
            conv_b_ff <= wr_data & data_memory_pkg::converter_control_b_mask;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // General purpose RAM
  // ****************************************
  // No reset on the array: contents are undefined after power-up
  always_ff @(posedge mclk) begin
    if (do_write && in_gpr) begin
      gpr_mem[gpr_index] <= wr_data;
    end
  end

  assign gpr_rd = gpr_mem[gpr_index];

  // ****************************************
  // Mirrored read decode
  // ****************************************
  // Seven-bit decode lets either bank reach the same flop
  always_comb begin
    mirror_rd = 8'h00;
    case (map_addr[6:0])
      data_memory_pkg::program_counter_low_offs[6:0]: mirror_rd = pc_low_ff;
      data_memory_pkg::status_flags_offs[6:0]: mirror_rd = status_ff;
      data_memory_pkg::file_select_pointer_offs[6:0]: mirror_rd = pointer_ff;
      data_memory_pkg::converter_result_offs[6:0]: mirror_rd = result_ff;
      data_memory_pkg::program_counter_high_latch_offs[6:0]: mirror_rd = pc_high_ff;
      data_memory_pkg::interrupt_control_offs[6:0]: mirror_rd = intr_ff;
      default: mirror_rd = 8'h00;
    endcase
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rd_data = 8'h00;
    if (self_point) begin
      rd_data = 8'h00;
    end else if (in_gpr) begin
      rd_data = gpr_rd;
    end else begin
      case (map_addr)
        data_memory_pkg::timer_count_offs: rd_data = timer_ff;
        data_memory_pkg::port_a_pins_offs: rd_data = pin_a_sync_ff & data_memory_pkg::port_a_pins_mask;
        data_memory_pkg::port_b_pins_offs: rd_data = pin_b_sync_ff;
        data_memory_pkg::converter_control_a_offs: rd_data = conv_a_ff;
        data_memory_pkg::option_config_offs: rd_data = option_ff;
        data_memory_pkg::port_a_direction_offs: rd_data = dir_a_ff;
        data_memory_pkg::port_b_direction_offs: rd_data = dir_b_ff;
        data_memory_pkg::power_control_flags_offs: rd_data = power_ff;
        data_memory_pkg::converter_control_b_offs: rd_data = conv_b_ff;
        default: rd_data = mirror_rd;
      endcase
    end
  end

  // ****************************************
  // Register outputs
  // ****************************************
  // Straight from the flops so the core sees no decode glitches
  assign status_out = status_ff;
  assign pointer_out = pointer_ff;
  assign pc_high_latch_out = pc_high_ff;
  assign pc_low_out = pc_low_ff;
  assign timer_out = timer_ff;
  assign port_a_out = port_a_ff;
  assign port_b_out = port_b_ff;
  assign port_a_dir_out = dir_a_ff;
  assign port_b_dir_out = dir_b_ff;
  assign option_out = option_ff;
  assign intr_ctrl_out = intr_ff;
  assign conv_ctrl_a_out = conv_a_ff;
  assign conv_ctrl_b_out = conv_b_ff;
  assign power_ctrl_out = power_ff;

endmodule : banked_data_memory_indirect

/* rtl/data_memory_pkg.sv */
package data_memory_pkg;

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [6:0] indirect_data_port_offs = 7'h00;
  localparam logic [7:0] timer_count_offs = 8'h01;
  localparam logic [7:0] program_counter_low_offs = 8'h02;
  localparam logic [7:0] status_flags_offs = 8'h03;
  localparam logic [7:0] file_select_pointer_offs = 8'h04;
  localparam logic [7:0] port_a_pins_offs = 8'h05;
  localparam logic [7:0] port_b_pins_offs = 8'h06;
  localparam logic [7:0] converter_control_a_offs = 8'h08;
  localparam logic [7:0] converter_result_offs = 8'h09;
  localparam logic [7:0] program_counter_high_latch_offs = 8'h0A;
  localparam logic [7:0] interrupt_control_offs = 8'h0B;
  localparam logic [7:0] option_config_offs = 8'h81;
  localparam logic [7:0] port_a_direction_offs = 8'h85;
  localparam logic [7:0] port_b_direction_offs = 8'h86;
  localparam logic [7:0] power_control_flags_offs = 8'h87;
  localparam logic [7:0] converter_control_b_offs = 8'h88;

  // ****************************************
  // Memory layout
  // ****************************************
  localparam logic [6:0] bank_top = 7'h7F;
  localparam logic [6:0] gpr_first = 7'h0C;
  localparam logic [6:0] gpr_last = 7'h2F;
  localparam int gpr_words = 36;

  // ****************************************
  // Status register fields
  // ****************************************
  localparam int bank_select_pos = 5;
  localparam int indirect_upper_address_pos = 7;

  // ****************************************
  // Reset values and write masks
  // ****************************************
  localparam logic [7:0] status_flags_rst = 8'h18;
  localparam logic [7:0] zero_rst = 8'h00;
  localparam logic [7:0] all_ones_rst = 8'hFF;
  localparam logic [7:0] port_a_pins_dir_rst = 8'h1F;
  localparam logic [7:0] converter_control_a_mask = 8'hDF;
  localparam logic [7:0] port_a_pins_mask = 8'h1F;
  localparam logic [7:0] power_control_mask = 8'h03;
  localparam logic [7:0] converter_control_b_mask = 8'h03;
  localparam logic [7:0] pc_high_mask = 8'h1F;

endpackage : data_memory_pkg

/* sim/core_update_model.sv */
`timescale 1ns/10ps
module core_update_model (
  input wire logic mclk,
  input wire logic rst_n,
  output logic timer_wr_en,
  output logic [7:0] timer_in,
  output logic result_wr_en,
  output logic [7:0] result_in,
  output logic intr_flags_wr_en,
  output logic [7:0] intr_flags_in,
  output logic [7:0] port_a_in,
  output logic [7:0] port_b_in
);
  integer seed = 32'hD4B4F2BF;
  // Core side updates at random, like a free running timer and converter
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {timer_wr_en, result_wr_en, intr_flags_wr_en} <= 3'h0;
    end else begin
      {timer_wr_en, result_wr_en, intr_flags_wr_en} <= 3'($random(seed));
    end
    {timer_in, result_in, intr_flags_in} <= 24'($random(seed));
    {port_a_in, port_b_in} <= 16'($random(seed));
  end
endmodule : core_update_model

/* sim/bdm_monitor.sv */
`timescale 1ns/10ps
module bdm_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic status_wr_en,
  input wire logic [7:0] status_out,
  input wire logic [7:0] pointer_out,
  input wire logic [8:0] eff_addr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence self_wr_s;
    wr_en && file_addr == 7'h00 && pointer_out[6:0] == 7'h00 && !status_wr_en;
  endsequence
  sequence ram_wr_s;
    wr_en && file_addr >= 7'h0C && file_addr <= 7'h2F;
  endsequence
  sequence ind_wr_s;
    wr_en && file_addr == 7'h00 && pointer_out >= 8'h0C && pointer_out <= 8'h2F;
  endsequence
  direct_addr_a: assert property (file_addr != 7'h00 |->
    eff_addr == {1'b0, status_out[5], file_addr}) else $error("direct address");
  indirect_addr_a: assert property (file_addr == 7'h00 |->
    eff_addr == {status_out[7], pointer_out}) else $error("indirect address");
  self_read_a: assert property (file_addr == 7'h00 && pointer_out[6:0] == 7'h00 |->
    rd_data == 8'h00) else $error("self read");
  self_write_a: assert property (self_wr_s |=>
    $stable(pointer_out) && $stable(status_out)) else $error("self write");
  status_mirror_a: assert property (file_addr == 7'h03 |-> rd_data == status_out)
    else $error("status read");
  pointer_write_a: assert property (wr_en && file_addr == 7'h04 |=>
    pointer_out == $past(wr_data)) else $error("pointer write");
  ram_readback_a: assert property (ram_wr_s ##1 file_addr == $past(file_addr) |->
    rd_data == $past(wr_data)) else $error("ram readback");
  ind_readback_a: assert property (ind_wr_s ##1 file_addr == 7'h00 && $stable(pointer_out)
    |-> rd_data == $past(wr_data)) else $error("indirect readback");
  unmapped_zero_a: assert property (file_addr >= 7'h30 |-> rd_data == 8'h00)
    else $error("unmapped read");
endmodule : bdm_monitor
bind banked_data_memory_indirect bdm_monitor mon (.mclk, .rst_n, .file_addr, .rd_data,
  .wr_en, .wr_data, .status_wr_en, .status_out, .pointer_out, .eff_addr);

/* sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic mclk, rst_n, wr_en, status_wr_en, t_en, r_en, i_en;
  logic [6:0] file_addr, a;
  logic [7:0] wr_data, status_wr_data, rd_data, status_out, pointer_out, v, t_in, r_in, i_in;
  logic [7:0] pa_in, pb_in, pch_o, opt_o, dira_o;
  logic [8:0] eff_addr;
  logic [7:0] ram [12:47];
  integer seed = 32'hD4B4F2BF;
  int n_mismatch = 0;
  int samples_checked = 0;
  banked_data_memory_indirect dut (.mclk, .rst_n, .file_addr, .rd_data, .wr_en, .wr_data,
    .status_wr_en, .status_wr_data, .pc_low_wr_en(1'b0), .pc_low_in(8'h00),
    .timer_wr_en(t_en), .timer_in(t_in), .result_wr_en(r_en), .result_in(r_in),
    .intr_flags_wr_en(i_en), .intr_flags_in(i_in), .port_a_in(pa_in), .port_b_in(pb_in),
    .status_out, .pointer_out, .pc_high_latch_out(pch_o), .pc_low_out(), .timer_out(),
    .port_a_out(), .port_b_out(), .port_a_dir_out(dira_o), .port_b_dir_out(),
    .option_out(opt_o),
    .intr_ctrl_out(), .conv_ctrl_a_out(), .conv_ctrl_b_out(), .power_ctrl_out(), .eff_addr);
  core_update_model core (.mclk, .rst_n, .timer_wr_en(t_en), .timer_in(t_in),
    .result_wr_en(r_en), .result_in(r_in), .intr_flags_wr_en(i_en), .intr_flags_in(i_in),
    .port_a_in(pa_in), .port_b_in(pb_in));
  function automatic logic [8:0] exp_eff(logic [6:0] fa, logic [7:0] st, logic [7:0] p);
    return (fa == 7'h00) ? {st[7], p} : {1'b0, st[5], fa};
  endfunction : exp_eff
  task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte
  task automatic chk_addr(string what, logic [8:0] exp, logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_addr
  task automatic wr(logic [6:0] fa, logic [7:0] d, logic [7:0] st = 8'h00, logic s_en = 1'b0);
    @(posedge mclk);
    file_addr <= fa;
    wr_data <= d;
    wr_en <= 1'b1;
    status_wr_en <= s_en;
    status_wr_data <= st;
    @(posedge mclk);
    wr_en <= 1'b0;
    status_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(logic [6:0] fa);
    @(posedge mclk);
    file_addr <= fa;
    @(negedge mclk);
  endtask : rd
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Whole run is well under 1000 cycles
  initial begin
    #300000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {rst_n, wr_en, status_wr_en, file_addr, wr_data, status_wr_data} = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk_byte("reset status", 8'h18, status_out);
    chk_byte("reset option", 8'hFF, opt_o);
    wr(7'h03, 8'h38);
    rd(7'h01);
    chk_addr("bank1 addr", exp_eff(7'h01, 8'h38, 8'h00), eff_addr);
    chk_byte("bank1 option", 8'hFF, rd_data);
    v = 8'($random(seed));
    wr(7'h04, v);
    wr(7'h03, 8'h18);
    rd(7'h04);
    chk_byte("pointer mirror", v, rd_data);
    chk_addr("bank0 addr", exp_eff(7'h04, 8'h18, v), eff_addr);
    wr(7'h03, 8'h38);
    wr(7'h05, 8'hF3);
    wr(7'h0A, 8'hFF);
    @(negedge mclk);
    chk_byte("bank1 dir a", 8'h13, dira_o);
    chk_byte("mirror pc high", 8'h1F, pch_o);
    wr(7'h03, 8'h18);
    $display("test banking done");
    // Odd locations direct, even ones through the pointer
    for (int i = 12; i < 48; i++) begin
      a = 7'(i);
      v = 8'($random(seed));
      ram[i] = v;
      if (a[0]) wr(a, v);
      else begin
        wr(7'h04, {1'b0, a});
        wr(7'h00, v);
      end
    end
    for (int i = 12; i < 48; i++) begin
      rd(7'(i));
      chk_byte("ram direct", ram[i], rd_data);
      wr(7'h04, 8'(i));
      rd(7'h00);
      chk_byte("ram indirect", ram[i], rd_data);
    end
    wr(7'h30, 8'hA5);
    rd(7'h30);
    chk_byte("unmapped", 8'h00, rd_data);
    $display("test ram done");
    wr(7'h04, 8'h00);
    rd(7'h00);
    chk_byte("self read", 8'h00, rd_data);
    wr(7'h00, 8'hFF, 8'h1C, 1'b1);
    rd(7'h04);
    chk_byte("self write ptr", 8'h00, rd_data);
    chk_byte("self write flags", 8'h1C, status_out);
    wr(7'h04, 8'h80);
    wr(7'h00, 8'h77);
    rd(7'h00);
    chk_byte("self read high", 8'h00, rd_data);
    wr(7'h03, 8'h98);
    wr(7'h04, 8'h20);
    rd(7'h00);
    chk_addr("upper bit addr", exp_eff(7'h00, 8'h98, 8'h20), eff_addr);
    chk_byte("upper bit data", ram[32], rd_data);
    $display("test indirect done");
    end_of_test();
  end
endmodule : tb_top
